/* hw/acrr_top.sv */
// control, result registers and successive-approximation sequencer of a 10-bit converter
// assumes an analog front end: channel mux, sample switch, DAC and comparator outside
//
// Contract
// - done flag sets at end, clears on result read
// - with irq enabled done flag stays zero
// - irq pulses per conversion, cleared by read/write
// - continuous mode runs back-to-back, updating results
// - single mode: one conversion per status write
// - five-bit channel, inputs 0-7, two references
// - all-ones channel powers converter off
// - unused channel codes give undefined results
// - left format: eight high bits, two low
// - high read freezes low until low read
// - right format: two high bits, eight low
// - signed left format inverts result msb
// - truncation: low gets top eight, no interlock
// - divider 1,2,4,8, top bit set gives 16
// - input clock select, reset picks oscillator
// - justify codes; reset gives right-justified
// - write starts conversion of 16-17 converter clocks
`timescale 1ns/10ps
`default_nettype none

module acrr_top
   import acrr_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // oscillator clock, as a one-cycle enable pulse
   input  wire logic        oscillator_clock_tick,
   // analog front end
   input  wire logic        comparator_above,
   output logic      [9:0]  dac_code,
   output logic             sample_hold,
   output logic      [4:0]  channel_select,
   output logic             converter_power_on,
   // conversion interrupt request
   output logic             done_irq
);

   // register state
   logic        done_flag;
   logic        irq_en;
   logic        continuous;
   logic [2:0]  div_sel;
   logic        clk_sel;
   acrr_just_t  just;
   logic [7:0]  result_high;
   logic [7:0]  result_low;
   logic        locked;

   // sequencer state
   acrr_state_t state;
   logic [3:0]  step;
   logic [3:0]  bit_idx;
   logic [3:0]  div_cnt;
   logic [3:0]  div_last;
   logic        in_tick;
   logic        conv_tick;
   logic        conv_end;
   logic        result_store;
   logic [9:0]  bit_mask;
   logic [9:0]  next_code;

   // bus decode
   logic        setup;
   logic        access;
   logic [5:0]  idx;
   logic        mapped;
   logic        status_wr;
   logic        clock_wr;
   logic        high_rd;
   logic        low_rd;
   logic        start;

   assign setup  = psel && !penable;
   assign access = psel && penable;
   assign idx    = paddr[7:2];
   assign mapped = (paddr[1:0] == 2'b00) && (idx == ACRR_IDX_STATUS || idx == ACRR_IDX_HIGH
                   || idx == ACRR_IDX_LOW || idx == ACRR_IDX_CLOCK);
   assign status_wr = access && pwrite && pstrb[0] && mapped && idx == ACRR_IDX_STATUS;
   assign clock_wr  = access && pwrite && pstrb[0] && mapped && idx == ACRR_IDX_CLOCK;
   assign high_rd   = access && !pwrite && mapped && idx == ACRR_IDX_HIGH;
   assign low_rd    = access && !pwrite && mapped && idx == ACRR_IDX_LOW;
   // power-off code never starts a conversion
   assign start     = status_wr
                      && pwdata[ACRR_CHAN_LSB +: 5] != ACRR_CHAN_POWER_OFF;

   // zero wait states: read data is captured in the setup cycle
   assign pready = 1'b1;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (setup)
      begin
         pslverr <= !mapped;
         case (idx)
            ACRR_IDX_STATUS: prdata <= {24'h00_0000, done_flag && !irq_en, irq_en,
                                        continuous, channel_select};
            ACRR_IDX_HIGH:   prdata <= {24'h00_0000, result_high};
            ACRR_IDX_LOW:    prdata <= {24'h00_0000, result_low};
            ACRR_IDX_CLOCK:  prdata <= {24'h00_0000, div_sel, clk_sel, just, 2'b00};
            default:         prdata <= 32'h0000_0000;
         endcase
         if (!mapped)
         begin
            prdata <= 32'h0000_0000;
         end
      end
   end

   // status/control; the done bit position is ignored on write
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         irq_en             <= ACRR_STATUS_RESET[ACRR_IRQEN_BIT];
         continuous         <= ACRR_STATUS_RESET[ACRR_CONT_BIT];
         channel_select     <= ACRR_STATUS_RESET[ACRR_CHAN_LSB +: 5];
         converter_power_on <= 1'b0;
      end
      else if (status_wr)
      begin
         irq_en             <= pwdata[ACRR_IRQEN_BIT];
         continuous         <= pwdata[ACRR_CONT_BIT];
         channel_select     <= pwdata[ACRR_CHAN_LSB +: 5];
         converter_power_on <= pwdata[ACRR_CHAN_LSB +: 5] != ACRR_CHAN_POWER_OFF;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         div_sel <= ACRR_CLOCK_RESET[ACRR_DIV_LSB +: 3];
         clk_sel <= ACRR_CLOCK_RESET[ACRR_CLKSEL_BIT];
         just    <= acrr_just_t'(ACRR_CLOCK_RESET[ACRR_MODE_LSB +: 2]);
      end
      else if (clock_wr)
      begin
         div_sel <= pwdata[ACRR_DIV_LSB +: 3];
         clk_sel <= pwdata[ACRR_CLKSEL_BIT];
         just    <= acrr_just_t'(pwdata[ACRR_MODE_LSB +: 2]);
      end
   end

   // converter clock: selected input enable divided by a power of two
   assign in_tick = clk_sel ? 1'b1 : oscillator_clock_tick;

   always_comb
   begin
      case (div_sel)
         3'h0:    div_last = 4'h0;
         3'h1:    div_last = 4'h1;
         3'h2:    div_last = 4'h3;
         3'h3:    div_last = 4'h7;
         default: div_last = 4'hF;
      endcase
   end

   assign conv_tick = in_tick && div_cnt == div_last;

   // restart the prescaler on a start so the first period is whole
   always_ff @(posedge clk)
   begin
      if (rst || status_wr)
      begin
         div_cnt <= 4'h0;
      end
      else if (conv_tick)
      begin
         div_cnt <= 4'h0;
      end
      else if (in_tick)
      begin
         div_cnt <= div_cnt + 4'h1;
      end
   end

   // sequencer
   assign bit_mask  = 10'(10'h001 << bit_idx);
   assign next_code = comparator_above ? dac_code : (dac_code & ~bit_mask);
   assign conv_end  = !status_wr && converter_power_on && conv_tick
                      && state == ACRR_ST_FINISH && step == ACRR_FINISH_TICKS - 4'h1;
   assign sample_hold = state == ACRR_ST_SAMPLE;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state    <= ACRR_ST_IDLE;
         step     <= 4'h0;
         bit_idx  <= ACRR_TOP_BIT;
         dac_code <= 10'h000;
      end
      else if (status_wr)
      begin
         // a write mid-conversion throws the partial result away
         state    <= start ? ACRR_ST_SAMPLE : ACRR_ST_IDLE;
         step     <= 4'h0;
         bit_idx  <= ACRR_TOP_BIT;
      end
      else if (!converter_power_on)
      begin
         state <= ACRR_ST_IDLE;
      end
      else if (conv_tick)
      begin
         case (state)
            ACRR_ST_SAMPLE:
            begin
               if (step == ACRR_SAMPLE_TICKS - 4'h1)
               begin
                  state    <= ACRR_ST_CONVERT;
                  step     <= 4'h0;
                  bit_idx  <= ACRR_TOP_BIT;
                  dac_code <= 10'h200;
               end
               else
               begin
                  step <= step + 4'h1;
               end
            end
            ACRR_ST_CONVERT:
            begin
               if (bit_idx == 4'h0)
               begin
                  dac_code <= next_code;
                  state    <= ACRR_ST_FINISH;
               end
               else
               begin
                  dac_code <= next_code | (bit_mask >> 1);
                  bit_idx  <= bit_idx - 4'h1;
               end
            end
            ACRR_ST_FINISH:
            begin
               if (step == ACRR_FINISH_TICKS - 4'h1)
               begin
                  state <= continuous ? ACRR_ST_SAMPLE : ACRR_ST_IDLE;
                  step  <= 4'h0;
               end
               else
               begin
                  step <= step + 4'h1;
               end
            end
            default:
            begin
               state <= ACRR_ST_IDLE;
            end
         endcase
      end
   end

   // done flag and interrupt; a new event wins over a same-cycle read clear, a same-cycle status write cancels the event
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         done_flag <= 1'b0;
      end
      else if (conv_end && !irq_en)
      begin
         done_flag <= 1'b1;
      end
      else if (high_rd || low_rd || (status_wr && pwdata[ACRR_IRQEN_BIT]))
      begin
         done_flag <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         done_irq <= 1'b0;
      end
      else if (conv_end && irq_en)
      begin
         done_irq <= 1'b1;
      end
      else if (high_rd || low_rd || status_wr)
      begin
         done_irq <= 1'b0;
      end
   end

   // results; truncation format has no interlock
   assign result_store = conv_end && (just == ACRR_JUST_TRUNC || (!locked && !high_rd));

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         locked <= 1'b0;
      end
      else if (just == ACRR_JUST_TRUNC)
      begin
         locked <= 1'b0;
      end
      else if (high_rd)
      begin
         locked <= 1'b1;
      end
      else if (low_rd)
      begin
         locked <= 1'b0;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         result_high <= 8'h00;
         result_low  <= 8'h00;
      end
      else if (result_store)
      begin
         case (just)
            ACRR_JUST_TRUNC:
            begin
               result_high <= 8'h00;
               result_low  <= dac_code[9:2];
            end
            ACRR_JUST_RIGHT:
            begin
               result_high <= {6'h00, dac_code[9:8]};
               result_low  <= dac_code[7:0];
            end
            ACRR_JUST_LEFT:
            begin
               result_high <= dac_code[9:2];
               result_low  <= {dac_code[1:0], 6'h00};
            end
            default:
            begin
               result_high <= {~dac_code[9], dac_code[8:2]};
               result_low  <= {dac_code[1:0], 6'h00};
            end
         endcase
      end
   end

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   done_rise_a: assert property (conv_end && !irq_en |=> done_flag)
      else $error("done flag not set after conversion end");

   done_zero_a: assert property (irq_en |-> !done_flag)
      else $error("done flag set while interrupt enabled");

   irq_set_a: assert property (conv_end && irq_en |=> done_irq)
      else $error("interrupt not raised at conversion end");

   irq_clear_a: assert property ((status_wr || high_rd || low_rd) && !conv_end |=> !done_irq)
      else $error("interrupt not dropped after read or write");

   cont_restart_a: assert property (conv_end && continuous |=> state == ACRR_ST_SAMPLE)
      else $error("continuous mode did not restart");

   single_stop_a: assert property (conv_end && !continuous |=> state == ACRR_ST_IDLE)
      else $error("single mode did not stop");

   power_off_a: assert property (!converter_power_on && !status_wr |=> state == ACRR_ST_IDLE)
      else $error("converter runs while powered off");

   restart_a: assert property (start |=> state == ACRR_ST_SAMPLE && step == 4'h0)
      else $error("status write did not restart conversion");

   right_just_a: assert property (result_store && just == ACRR_JUST_RIGHT
      |=> result_high[7:2] == 6'h00 && result_low == $past(dac_code[7:0]))
      else $error("right-justified placement wrong");

   left_just_a: assert property (result_store && just == ACRR_JUST_LEFT
      |=> result_high == $past(dac_code[9:2]) && result_low[5:0] == 6'h00)
      else $error("left-justified placement wrong");

   signed_msb_a: assert property (result_store && just == ACRR_JUST_SIGNED
      |=> result_high[7] != $past(dac_code[9]))
      else $error("signed format msb not inverted");

   trunc_fmt_a: assert property (result_store && just == ACRR_JUST_TRUNC
      |=> result_high == 8'h00 && result_low == $past(dac_code[9:2]))
      else $error("truncation placement wrong");

   lock_hold_a: assert property (locked && !low_rd && just != ACRR_JUST_TRUNC
      |=> $stable(result_low) && $stable(result_high))
      else $error("results changed while interlocked");

   div_rate_a: assert property (in_tick && div_sel == 3'h2 && div_cnt == 4'h3 |-> conv_tick)
      else $error("divide-by-4 tick missing");

endmodule // acrr_top

`default_nettype wire

/* inc/acrr_pkg.sv */
// constants, field layout and state encodings of the converter control block
// assumes APB with 32-bit data; each register sits in the low byte of one word
package acrr_pkg;

   // register indices; byte address is four times the index
   localparam logic [5:0] ACRR_IDX_STATUS = 6'h3C;
   localparam logic [5:0] ACRR_IDX_HIGH   = 6'h3D;
   localparam logic [5:0] ACRR_IDX_LOW    = 6'h3E;
   localparam logic [5:0] ACRR_IDX_CLOCK  = 6'h3F;
   localparam logic [7:0] ACRR_ADDR_STATUS = {ACRR_IDX_STATUS, 2'b00};
   localparam logic [7:0] ACRR_ADDR_HIGH   = {ACRR_IDX_HIGH, 2'b00};
   localparam logic [7:0] ACRR_ADDR_LOW    = {ACRR_IDX_LOW, 2'b00};
   localparam logic [7:0] ACRR_ADDR_CLOCK  = {ACRR_IDX_CLOCK, 2'b00};

   // status/control fields
   localparam int ACRR_DONE_BIT  = 7;
   localparam int ACRR_IRQEN_BIT = 6;
   localparam int ACRR_CONT_BIT  = 5;
   localparam int ACRR_CHAN_LSB  = 0;
   // clock config fields
   localparam int ACRR_DIV_LSB    = 5;
   localparam int ACRR_CLKSEL_BIT = 4;
   localparam int ACRR_MODE_LSB   = 2;

   localparam logic [7:0] ACRR_STATUS_RESET = 8'h1F;
   localparam logic [7:0] ACRR_CLOCK_RESET  = 8'h04;

   // channel codes
   localparam logic [4:0] ACRR_CHAN_LAST_INPUT = 5'h07;
   localparam logic [4:0] ACRR_CHAN_REF_HIGH   = 5'h1D;
   localparam logic [4:0] ACRR_CHAN_REF_LOW    = 5'h1E;
   localparam logic [4:0] ACRR_CHAN_POWER_OFF  = 5'h1F;

   // converter clock ticks per phase: 4 + 10 + 2 = 16
   localparam logic [3:0] ACRR_SAMPLE_TICKS = 4'h4;
   localparam logic [3:0] ACRR_FINISH_TICKS = 4'h2;
   localparam logic [3:0] ACRR_TOP_BIT      = 4'h9;

   typedef enum logic [1:0] {
      ACRR_JUST_TRUNC  = 2'b00,
      ACRR_JUST_RIGHT  = 2'b01,
      ACRR_JUST_LEFT   = 2'b10,
      ACRR_JUST_SIGNED = 2'b11
   } acrr_just_t;

   typedef enum logic [1:0] {
      ACRR_ST_IDLE    = 2'b00,
      ACRR_ST_SAMPLE  = 2'b01,
      ACRR_ST_CONVERT = 2'b11,
      ACRR_ST_FINISH  = 2'b10
   } acrr_state_t;

endpackage

/* verif/acrr_afe_model.sv */
// analog front end stand-in: channel mux, sample-and-hold and comparator
// assumes the converter holds sample_hold high while sampling, then trials dac_code
`timescale 1ns/10ps
`default_nettype none

module acrr_afe_model
   import acrr_pkg::*;
(
   // clock
   input  wire logic       clk,
   // from the converter logic
   input  wire logic [9:0] dac_code,
   input  wire logic       sample_hold,
   input  wire logic [4:0] channel_select,
   input  wire logic       converter_power_on,
   // level on the selected input pin
   input  wire logic [9:0] ain,
   // to the converter logic
   output logic            comparator_above
);
   logic [9:0] held = 10'h000;
   logic [9:0] pick;
   logic       flip = 1'b0;

   always_comb
   begin
      if (channel_select <= ACRR_CHAN_LAST_INPUT)
         pick = ain;
      else if (channel_select == ACRR_CHAN_REF_HIGH)
         pick = 10'h3FF;
      else if (channel_select == ACRR_CHAN_REF_LOW)
         pick = 10'h000;
      else
         pick = ~ain; // unused codes give junk
   end

   always_ff @(posedge clk)
   begin
      flip <= ~flip;
      if (sample_hold)
         held <= pick;
   end

   // powered down, the comparator output means nothing, so it toggles
   assign comparator_above = converter_power_on ? (held >= dac_code) : flip;
endmodule // acrr_afe_model

`default_nettype wire

/* verif/tb.sv */
// self-checking bench of the converter control block over APB
// assumes acrr_pkg and the front-end model are compiled first
`timescale 1ns/10ps
`default_nettype none

module tb;
   import acrr_pkg::*;
   typedef struct {logic [7:0] cfg; logic [4:0] ch; logic [9:0] lvl; int d;} acrr_row_t;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        osc = 1'b0;
   logic [1:0]  ocnt = 2'h0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  strb = 4'hF;
   logic [9:0]  ain = 10'h000;
   logic [31:0] prdata;
   logic [9:0]  dac;
   logic [4:0]  chan;
   logic        pready, pslverr, shold, pwr_on, cmp, done_irq, e;
   logic [7:0]  r;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          n;
   // config, channel, level, clk cycles per converter tick
   acrr_row_t rows [0:10] = '{
      '{8'h14, 5'h00, 10'h2D6, 1}, '{8'h18, 5'h01, 10'h2D6, 1}, '{8'h1C, 5'h02, 10'h2D6, 1},
      '{8'h10, 5'h03, 10'h2D6, 1}, '{8'h1C, 5'h04, 10'h155, 1}, '{8'h34, 5'h05, 10'h3A1, 2},
      '{8'h54, 5'h06, 10'h0C7, 4}, '{8'h74, 5'h07, 10'h200, 8}, '{8'h94, 5'h1D, 10'h3FF, 16},
      '{8'hF4, 5'h1E, 10'h000, 16}, '{8'h04, 5'h00, 10'h13B, 4}};

   acrr_top i_acrr_top (
      .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .oscillator_clock_tick(osc), .comparator_above(cmp), .dac_code(dac),
      .sample_hold(shold), .channel_select(chan), .converter_power_on(pwr_on),
      .done_irq(done_irq));

   acrr_afe_model i_acrr_afe_model (
      .clk(clk), .dac_code(dac), .sample_hold(shold), .channel_select(chan),
      .converter_power_on(pwr_on), .ain(ain), .comparator_above(cmp));

   initial
   begin
      forever #20 clk = ~clk;
   end

   // oscillator stand-in at a quarter of the bus rate; the model ignores rate
   always @(posedge clk)
   begin
      ocnt <= ocnt + 2'h1;
      osc  <= (ocnt == 2'h3);
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
         error_cnt++;
      end
   endtask

   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
      int k;
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, wd};
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge clk);
         k++;
      end
      while (pready !== 1'b1 && k < 16);
      if (pready !== 1'b1)
      begin
         error_cnt++;
         complete_run();
      end
      rd = prdata[7:0];
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] x;
      logic       y;
      apb(1'b1, a, d, x, y);
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] x;
      logic       y;
      apb(1'b0, a, 8'h00, x, y);
      chk(nm, 32'(x), 32'(exp));
   endtask

   task automatic rpair(input string nm, input logic [15:0] exp);
      rchk(nm, ACRR_ADDR_HIGH, exp[15:8]);
      rchk(nm, ACRR_ADDR_LOW, exp[7:0]);
   endtask

   // cycles from the write edge to the interrupt, bounded
   task automatic wait_irq(output int c);
      c = 0;
      do
      begin
         @(negedge clk);
         c++;
      end
      while (done_irq !== 1'b1 && c < 400);
      if (c >= 400)
      begin
         error_cnt++;
         complete_run();
      end
      @(posedge clk);
   endtask

   function automatic logic [15:0] fmt(input logic [1:0] m, input logic [9:0] v);
      case (m)
         2'h0:    fmt = {8'h00, v[9:2]};
         2'h1:    fmt = {6'h00, v};
         2'h2:    fmt = {v, 6'h00};
         default: fmt = {~v[9], v[8:0], 6'h00};
      endcase
   endfunction

   task automatic do_row(input acrr_row_t w);
      int c;
      wr(ACRR_ADDR_CLOCK, w.cfg);
      ain <= (w.ch <= 5'h07) ? w.lvl : ~w.lvl;
      wr(ACRR_ADDR_STATUS, {3'h2, w.ch});
      wait_irq(c);
      chk("conv_time", 32'(c >= 15 * w.d + 1 && c <= 17 * w.d), 32'h1);
      chk("dac_hold", 32'(dac), 32'(w.lvl));
      rchk("status", ACRR_ADDR_STATUS, {3'h2, w.ch});
      rpair("result", fmt(w.cfg[3:2], w.lvl));
      chk("irq_read", 32'(done_irq), 32'h0);
   endtask

   initial
   begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rchk("status_rst", ACRR_ADDR_STATUS, 8'h1F);
      rchk("clock_rst", ACRR_ADDR_CLOCK, 8'h04);
      chk("power_rst", 32'(pwr_on), 32'h0);
      apb(1'b0, 8'h00, 8'h00, r, e);
      chk("unmapped", 32'(e), 32'h1);
      apb(1'b0, 8'hF1, 8'h00, r, e);
      chk("misaligned", 32'(e), 32'h1);
      wr(ACRR_ADDR_HIGH, 8'h5A);
      rchk("high_ro", ACRR_ADDR_HIGH, 8'h00);
      // that high read locked the pair; release it before converting
      rchk("low_ro", ACRR_ADDR_LOW, 8'h00);
      wr(ACRR_ADDR_CLOCK, 8'hFF);
      rchk("clock_rsvd", ACRR_ADDR_CLOCK, 8'hFC);
      strb <= 4'h0;
      wr(ACRR_ADDR_STATUS, 8'h45);
      strb <= 4'hF;
      rchk("strb_off", ACRR_ADDR_STATUS, 8'h1F);
      // one extra conversion of rows[0] after power-off, checked like every row, lets the front end settle
      do_row(rows[0]);
      foreach (rows[i])
         do_row(rows[i]);
      // single mode without interrupt, then the high/low interlock
      wr(ACRR_ADDR_CLOCK, 8'h14);
      ain <= 10'h1A5;
      wr(ACRR_ADDR_STATUS, 8'h02);
      repeat (20) @(posedge clk);
      chk("irq_off", 32'(done_irq), 32'h0);
      rchk("done_set", ACRR_ADDR_STATUS, 8'h82);
      rchk("hi_a", ACRR_ADDR_HIGH, 8'h01);
      ain <= 10'h2C3;
      wr(ACRR_ADDR_STATUS, 8'h02);
      repeat (20) @(posedge clk);
      rchk("low_frozen", ACRR_ADDR_LOW, 8'hA5);
      rchk("done_clr", ACRR_ADDR_STATUS, 8'h02);
      repeat (40) @(posedge clk);
      rpair("kept", 16'h01A5);
      // truncation has no interlock
      wr(ACRR_ADDR_CLOCK, 8'h10);
      wr(ACRR_ADDR_STATUS, 8'h02);
      repeat (20) @(posedge clk);
      rchk("tr_hi", ACRR_ADDR_HIGH, 8'h00);
      ain <= 10'h0F0;
      wr(ACRR_ADDR_STATUS, 8'h02);
      repeat (20) @(posedge clk);
      rchk("tr_lo", ACRR_ADDR_LOW, 8'h3C);
      // continuous mode follows the input without further writes
      wr(ACRR_ADDR_CLOCK, 8'h14);
      ain <= 10'h111;
      wr(ACRR_ADDR_STATUS, 8'h60);
      wait_irq(n);
      rpair("cont_a", 16'h0111);
      ain <= 10'h222;
      wait_irq(n);
      // second conversion sampled before the input moved
      rpair("cont_x", 16'h0111);
      wait_irq(n);
      chk("cont_gap", 32'(n <= 17), 32'h1);
      rpair("cont_b", 16'h0222);
      // power off stops everything; a result read drops any late request
      wr(ACRR_ADDR_STATUS, 8'h1F);
      rchk("off_lo", ACRR_ADDR_LOW, 8'h22);
      repeat (40) @(posedge clk);
      chk("off_irq", 32'(done_irq), 32'h0);
      chk("off_pwr", 32'({pwr_on, chan}), 32'h1F);
      // a second write mid-conversion restarts on the new channel
      ain <= 10'h055;
      wr(ACRR_ADDR_STATUS, 8'h40);
      chk("on_pwr", 32'(pwr_on), 32'h1);
      repeat (8) @(posedge clk);
      wr(ACRR_ADDR_STATUS, 8'h5D);
      wait_irq(n);
      chk("restart_time", 32'(n >= 16 && n <= 17), 32'h1);
      wr(ACRR_ADDR_STATUS, 8'h1D);
      chk("irq_wr", 32'(done_irq), 32'h0);
      rpair("restart", 16'h03FF);
      // reset in mid-conversion
      wr(ACRR_ADDR_STATUS, 8'h60);
      repeat (5) @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      chk("rst_sh", 32'({done_irq, shold}), 32'h0);
      rchk("rst_status", ACRR_ADDR_STATUS, 8'h1F);
      complete_run();
   end
endmodule // tb

`default_nettype wire
